/* File: hw/pws_top.sv */
/*
 * PWM output stage: pin enable, steering, polarity, single-phase and
 * complementary fixed-duty modes with dead-band and fractional adjust,
 * and burst modulation from one selectable source.
 * Assumes period/rise/fall event pulses from a timing core on i_clk_sys
 * and an APB master on the same clock.
 */
// The register addresses and the APB register port were left to the implementer.
// Behaviour
// - Disabled pin: block releases the pin
// - Enabled pin carries the active waveform
// - Enabled but unsteered pin holds inactive level
// - Six channels, each enable, steer, polarity
// - Steering used only in steerable modes
// - Per-channel polarity selects active level
// - Mode field picks waveform from events
// - Software steps steering in six-step mode
// - Single-phase mode has no dead-band
// - Same waveform on all steered channels; complementary single mode inverts channels 1, 3 and 5
// - Rise event drives steered outputs active
// - Fall event drives steered outputs inactive
// - Complementary fixed mode uses period events only
// - Rising uses rise dead-band, falling fall
// - Primary on A, complement on B only
// - Going active: comp off, add, band, primary
// - Going inactive: primary off, add, band, comp
// - Burst enabled: source gates output running
// - Burst disabled: outputs run continuously
// - One burst source selected at once
// - Software gate bit acts as source
// - Burst start begins a fresh period
// - Burst stop finishes period, then freezes
// - Fixed-duty stop waits for inactive edge
`timescale 1ns/1ps
`default_nettype none
module pws_top
    import pws_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [pws_pkg::PWS_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Timing core events and requests
    input wire pws_pkg::pws_evt_t i_evt,
    output logic o_period_restart,
    output logic o_period_stretch,
    // Burst sources
    input wire logic i_burst_input_pin,
    input wire pws_pkg::pws_mod_src_t i_mod_src,
    // Pins
    output logic [pws_pkg::PWS_NCH-1:0] o_pin_out,
    output logic [pws_pkg::PWS_NCH-1:0] o_pin_oe
);
    import pws_pkg::*;

    function automatic logic [5:0] pws_apply_pol(
        input logic [5:0] wave,
        input logic [5:0] pol
    );
        pws_apply_pol = wave ^ pol;
    endfunction

    // Software-visible state
    pws_mode_t pwm_main_control;
    logic [5:0] pwm_pin_drive_enables;
    logic [5:0] pwm_steering_control;
    logic [5:0] pwm_polarity_control;
    logic burst_enable;
    logic burst_soft_gate;
    pws_src_t burst_src_sel;
    logic [3:0] fractional_period_adjust;
    logic [7:0] db_rise;
    logic [7:0] db_fall;

    // Waveform state
    logic primary;
    logic compl_out;
    logic running;
    logic stopping;
    logic [3:0] fractional_accumulator;
    logic [7:0] db_cnt;
    logic db_busy;
    logic db_to_primary;
    logic gate_q;
    logic sync1;
    logic sync2;
    logic sync3;
    logic pin_lvl;
    logic [5:0] chan_wave;

    // APB decode
    wire logic setup_ph = i_psel & ~i_penable;
    wire logic access_ph = i_psel & i_penable;
    wire logic hit_ctrl = (i_paddr == PWS_OFF_CTRL);
    wire logic hit_oen = (i_paddr == PWS_OFF_OEN);
    wire logic hit_steer = (i_paddr == PWS_OFF_STEER);
    wire logic hit_pol = (i_paddr == PWS_OFF_POL);
    wire logic hit_burst = (i_paddr == PWS_OFF_BURST);
    wire logic hit_frac = (i_paddr == PWS_OFF_FRAC);
    wire logic hit_dband = (i_paddr == PWS_OFF_DBAND);
    wire logic hit_stat = (i_paddr == PWS_OFF_STAT);
    wire logic mapped = hit_ctrl | hit_oen | hit_steer | hit_pol |
        hit_burst | hit_frac | hit_dband | hit_stat;
    wire logic wr_en = access_ph & i_pwrite & mapped;

    assign o_pready = access_ph;
    assign o_pslverr = access_ph & ~mapped;

    // Read mux
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (1'b1)
            hit_ctrl: rd_val[2:0] = pwm_main_control;
            hit_oen: rd_val[5:0] = pwm_pin_drive_enables;
            hit_steer: rd_val[5:0] = pwm_steering_control;
            hit_pol: rd_val[5:0] = pwm_polarity_control;
            hit_burst:
            begin
                rd_val[PWS_BURST_EN_BIT] = burst_enable;
                rd_val[PWS_BURST_SOFT_BIT] = burst_soft_gate;
                rd_val[PWS_BURST_SEL_LSB +: 3] = burst_src_sel;
            end
            hit_frac: rd_val[3:0] = fractional_period_adjust;
            hit_dband: rd_val[15:0] = {db_fall, db_rise};
            hit_stat:
            begin
                rd_val[5:0] = chan_wave;
                rd_val[PWS_STAT_RUN_BIT] = running;
                rd_val[PWS_STAT_PRI_BIT] = primary;
                rd_val[PWS_STAT_CMP_BIT] = compl_out;
                rd_val[PWS_STAT_ACC_LSB +: 4] = fractional_accumulator;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            o_prdata <= 32'h0000_0000;
        else if (setup_ph & ~i_pwrite)
            o_prdata <= rd_val;
    end

    // Register writes
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            pwm_main_control <= pws_mode_t'(PWS_RST_MODE);
            pwm_pin_drive_enables <= PWS_RST_CH;
            pwm_steering_control <= PWS_RST_CH;
            pwm_polarity_control <= PWS_RST_CH;
            burst_enable <= 1'b0;
            burst_soft_gate <= 1'b0;
            burst_src_sel <= pws_src_t'(PWS_RST_SEL);
            fractional_period_adjust <= PWS_RST_FRAC;
            db_rise <= PWS_RST_DB;
            db_fall <= PWS_RST_DB;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                pwm_main_control <= pws_mode_t'(i_pwdata[2:0]);
            if (hit_oen)
                pwm_pin_drive_enables <= i_pwdata[5:0];
            if (hit_steer)
                pwm_steering_control <= i_pwdata[5:0];
            if (hit_pol)
                pwm_polarity_control <= i_pwdata[5:0];
            if (hit_burst)
            begin
                burst_enable <= i_pwdata[PWS_BURST_EN_BIT];
                burst_soft_gate <= i_pwdata[PWS_BURST_SOFT_BIT];
                burst_src_sel <= pws_src_t'(i_pwdata[PWS_BURST_SEL_LSB +: 3]);
            end
            if (hit_frac)
                fractional_period_adjust <= i_pwdata[3:0];
            if (hit_dband)
            begin
                db_rise <= i_pwdata[7:0];
                db_fall <= i_pwdata[PWS_DB_FALL_LSB +: 8];
            end
        end
    end

    // Burst pin synchroniser; level moves once stages two and three agree
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            {sync1, sync2, sync3, pin_lvl} <= 4'h0;
        else
        begin
            {sync3, sync2, sync1} <= {sync2, sync1, i_burst_input_pin};
            if (sync2 == sync3)
                pin_lvl <= sync3;
        end
    end

    // Burst source selection
    logic src_lvl;
    always_comb
    begin
        case (burst_src_sel)
            PWS_SRC_PIN: src_lvl = pin_lvl;
            PWS_SRC_CCP0: src_lvl = i_mod_src.capture_compare_output[0];
            PWS_SRC_CCP1: src_lvl = i_mod_src.capture_compare_output[1];
            PWS_SRC_CMP0: src_lvl = i_mod_src.comparator_output[0];
            PWS_SRC_CMP1: src_lvl = i_mod_src.comparator_output[1];
            PWS_SRC_SOFT: src_lvl = burst_soft_gate;
            default: src_lvl = burst_soft_gate;
        endcase
    end

    wire logic gate = burst_enable ? src_lvl : 1'b1;
    wire logic gate_rise = gate & ~gate_q;
    wire logic gate_fall = ~gate & gate_q;
    wire logic fixed_mode = (pwm_main_control == PWS_MODE_FIXED_DUTY) |
        (pwm_main_control == PWS_MODE_FIXED_COMPL);
    wire logic compl_mode = (pwm_main_control == PWS_MODE_FIXED_COMPL);
    wire logic steer_mode = (pwm_main_control == PWS_MODE_SINGLE) |
        (pwm_main_control == PWS_MODE_COMPL_SINGLE) |
        (pwm_main_control == PWS_MODE_SIX_STEP);
    wire logic per_evt = running & i_evt.period;
    // Stop point: any period end, or in fixed modes the inactive edge
    wire logic stop_now = stopping & per_evt &
        (~fixed_mode | primary);
    wire logic [4:0] acc_sum = {1'b0, fractional_accumulator} +
        {1'b0, fractional_period_adjust};

    // Run control of the burst gate
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            {gate_q, running, stopping, o_period_restart} <= 4'h0;
        else
        begin
            gate_q <= gate;
            o_period_restart <= gate_rise;
            if (gate_rise)
            begin
                running <= 1'b1;
                stopping <= 1'b0;
            end
            else if (stop_now)
                {running, stopping} <= 2'b00;
            else if (gate_fall & running)
                stopping <= 1'b1;
        end
    end

    // Waveform generation
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            {primary, compl_out, db_busy, db_to_primary} <= 4'h0;
            fractional_accumulator <= PWS_RST_FRAC;
            db_cnt <= PWS_RST_DB;
            o_period_stretch <= 1'b0;
        end
        else
        begin
            o_period_stretch <= 1'b0;
            if (~running | stop_now)
            begin
                // Frozen: default inactive state
                primary <= 1'b0;
                compl_out <= 1'b0;
                db_busy <= 1'b0;
            end
            else if (fixed_mode)
            begin
                // Rise and fall events are ignored here
                if (per_evt)
                begin
                    fractional_accumulator <= acc_sum[3:0];
                    o_period_stretch <= acc_sum[4];
                    if (~primary)
                    begin
                        compl_out <= 1'b0;
                        db_to_primary <= 1'b1;
                        db_cnt <= db_rise;
                        db_busy <= compl_mode & (db_rise != 8'h00);
                        primary <= ~(compl_mode & (db_rise != 8'h00));
                    end
                    else
                    begin
                        primary <= 1'b0;
                        db_to_primary <= 1'b0;
                        db_cnt <= db_fall;
                        db_busy <= compl_mode & (db_fall != 8'h00);
                        compl_out <= compl_mode & (db_fall == 8'h00);
                    end
                end
                else if (db_busy)
                begin
                    if (db_cnt == 8'h01)
                    begin
                        db_busy <= 1'b0;
                        if (db_to_primary)
                            primary <= 1'b1;
                        else
                            compl_out <= 1'b1;
                    end
                    db_cnt <= db_cnt - 8'h01;
                end
            end
            else
            begin
                // Single-phase family, no dead-band
                compl_out <= 1'b0;
                db_busy <= 1'b0;
                if (i_evt.rise)
                    primary <= 1'b1;
                else if (i_evt.fall)
                    primary <= 1'b0;
            end
        end
    end

    // Per-channel waveform before polarity
    always_comb
    begin
        chan_wave = 6'h00;
        if (steer_mode)
        begin
            // Identical waveform on every steered channel, except complementary single mode inverts channels 1, 3 and 5
            chan_wave = pwm_steering_control & {6{primary}};
            if (pwm_main_control == PWS_MODE_COMPL_SINGLE)
                chan_wave = pwm_steering_control &
                    {~primary, primary, ~primary, primary,
                    ~primary, primary} & {6{running}};
        end
        else if (compl_mode)
            chan_wave = {4'h0, compl_out, primary};
        else
            chan_wave = {5'h00, primary};
    end

    // Pin stage: unsteered enabled pins sit at inactive level
    wire logic [5:0] next_pin_out =
        pws_apply_pol(chan_wave, pwm_polarity_control) &
        pwm_pin_drive_enables;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            o_pin_out <= PWS_RST_CH;
        else
            o_pin_out <= next_pin_out;
    end

    assign o_pin_oe = pwm_pin_drive_enables;
endmodule
`default_nettype wire

/* File: pkg/pws_pkg.sv */
/*
 * Shared constants and types of the PWM output stage with burst control.
 * Assumes a 32-bit APB slave port with byte addresses and word registers.
 */
`default_nettype none
package pws_pkg;
    localparam int unsigned PWS_NCH = 6;
    localparam int unsigned PWS_AW = 8;

    // Register byte offsets
    localparam logic [7:0] PWS_OFF_CTRL = 8'h00;
    localparam logic [7:0] PWS_OFF_OEN = 8'h04;
    localparam logic [7:0] PWS_OFF_STEER = 8'h08;
    localparam logic [7:0] PWS_OFF_POL = 8'h0c;
    localparam logic [7:0] PWS_OFF_BURST = 8'h10;
    localparam logic [7:0] PWS_OFF_FRAC = 8'h14;
    localparam logic [7:0] PWS_OFF_DBAND = 8'h18;
    localparam logic [7:0] PWS_OFF_STAT = 8'h1c;

    // Field positions
    localparam int unsigned PWS_BURST_EN_BIT = 0;
    localparam int unsigned PWS_BURST_SOFT_BIT = 1;
    localparam int unsigned PWS_BURST_SEL_LSB = 4;
    localparam int unsigned PWS_DB_FALL_LSB = 8;
    localparam int unsigned PWS_STAT_RUN_BIT = 8;
    localparam int unsigned PWS_STAT_PRI_BIT = 9;
    localparam int unsigned PWS_STAT_CMP_BIT = 10;
    localparam int unsigned PWS_STAT_ACC_LSB = 12;

    // Reset values
    localparam logic [2:0] PWS_RST_MODE = 3'h0;
    localparam logic [5:0] PWS_RST_CH = 6'h00;
    localparam logic [3:0] PWS_RST_FRAC = 4'h0;
    localparam logic [7:0] PWS_RST_DB = 8'h00;
    localparam logic [2:0] PWS_RST_SEL = 3'h0;

    typedef enum logic [2:0] {
        PWS_MODE_SINGLE = 3'b000,
        PWS_MODE_COMPL_SINGLE = 3'b001,
        PWS_MODE_SIX_STEP = 3'b010,
        PWS_MODE_FIXED_DUTY = 3'b011,
        PWS_MODE_FIXED_COMPL = 3'b100
    } pws_mode_t;

    typedef enum logic [2:0] {
        PWS_SRC_PIN = 3'b000,
        PWS_SRC_CCP0 = 3'b001,
        PWS_SRC_CCP1 = 3'b010,
        PWS_SRC_CMP0 = 3'b011,
        PWS_SRC_CMP1 = 3'b100,
        PWS_SRC_SOFT = 3'b101
    } pws_src_t;

    typedef struct packed {
        logic period;
        logic rise;
        logic fall;
    } pws_evt_t;

    typedef struct packed {
        logic [1:0] capture_compare_output;
        logic [1:0] comparator_output;
    } pws_mod_src_t;
endpackage
`default_nettype wire

/* File: verif/pws_chk.sv */
/* Port checker of the PWM output stage, bound into pws_top.
   Assumes zero-wait APB writes and one-cycle event pulses. */
`timescale 1ns/1ps
`default_nettype none
module pws_chk (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [pws_pkg::PWS_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Events and requests
    input wire pws_pkg::pws_evt_t i_evt,
    input wire logic o_period_restart,
    input wire logic o_period_stretch,
    // Burst sources
    input wire logic i_burst_input_pin,
    input wire pws_pkg::pws_mod_src_t i_mod_src,
    // Pins
    input wire logic [pws_pkg::PWS_NCH-1:0] o_pin_out,
    input wire logic [pws_pkg::PWS_NCH-1:0] o_pin_oe
);
    import pws_pkg::*;
    logic wr, ben;
    logic [2:0] mode, quiet;
    logic [5:0] oen, steer, pol;
    assign wr = i_psel && i_penable && i_pwrite;
    // Shadow of the control registers
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            {mode, oen, steer, pol, ben} <= '0;
        else if (wr)
        begin
            case (i_paddr)
                PWS_OFF_CTRL: mode <= i_pwdata[2:0];
                PWS_OFF_OEN: oen <= i_pwdata[5:0];
                PWS_OFF_STEER: steer <= i_pwdata[5:0];
                PWS_OFF_POL: pol <= i_pwdata[5:0];
                PWS_OFF_BURST: ben <= i_pwdata[PWS_BURST_EN_BIT];
                default: ;
            endcase
        end
    end
    // Cycles since the last register write
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            quiet <= 3'h0;
        else if (wr)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    chk_oe_follow: assert property (
        wr && i_paddr == PWS_OFF_OEN |=> o_pin_oe == oen)
        else $error("pin enables differ from written value");
    chk_oe_steady: assert property (
        !(wr && i_paddr == PWS_OFF_OEN) |=> $stable(o_pin_oe))
        else $error("pin enables changed without a write");
    chk_rise_active: assert property (
        mode == PWS_MODE_SINGLE && !ben && quiet >= 3'h1 && i_evt.rise
        && !wr ##1 !wr |=> ((o_pin_out ^ pol) & oen) == (steer & oen))
        else $error("steered pins not active after rise");
    chk_fall_idle: assert property (
        mode == PWS_MODE_SINGLE && !ben && quiet >= 3'h3 && i_evt.fall
        && !i_evt.rise && !wr ##1 !wr |=> ((o_pin_out ^ pol) & oen) == 0)
        else $error("pins not inactive after fall");
    chk_unsteer_idle: assert property (
        mode == PWS_MODE_SINGLE && quiet >= 3'h3
        |-> ((o_pin_out ^ pol) & oen & ~steer) == 6'h00)
        else $error("unsteered pin left inactive level");
    chk_only_ab: assert property (
        mode == PWS_MODE_FIXED_COMPL && quiet >= 3'h3
        |-> ((o_pin_out ^ pol) & oen & 6'h3c) == 6'h00)
        else $error("pin beyond A and B active in complementary mode");
    chk_band_gap: assert property (
        mode == PWS_MODE_FIXED_COMPL && quiet >= 3'h3
        |-> ((o_pin_out ^ pol) & oen & 6'h03) != 6'h03)
        else $error("primary and complement active together");
    chk_stretch_cause: assert property (
        o_period_stretch |-> $past(i_evt.period))
        else $error("stretch request without period event");
    chk_restart_pulse: assert property (
        o_period_restart |=> !o_period_restart)
        else $error("restart request longer than one cycle");
    chk_unmapped_err: assert property (
        i_psel && i_penable && i_paddr > PWS_OFF_STAT |-> o_pslverr)
        else $error("unmapped access not refused");
    cov_rise: cover property (mode == PWS_MODE_SINGLE && i_evt.rise);
    cov_period: cover property (mode == PWS_MODE_FIXED_COMPL && i_evt.period);
    cov_restart: cover property (o_period_restart);
    cov_stretch: cover property (o_period_stretch);
endmodule
bind pws_top pws_chk i_pws_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_evt(i_evt),
    .o_period_restart(o_period_restart),
    .o_period_stretch(o_period_stretch),
    .i_burst_input_pin(i_burst_input_pin), .i_mod_src(i_mod_src),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
`default_nettype wire

/* File: verif/pws_gate_load.sv */
/* Gate driver load on the six pins, with a GPIO that drives released pins.
   Assumes pin enables high while the block drives a pin. */
`timescale 1ns/1ps
`default_nettype none
module pws_gate_load (
    // Clock
    input wire logic i_clk_sys,
    // Pins from the block
    input wire logic [pws_pkg::PWS_NCH-1:0] i_pin_out,
    input wire logic [pws_pkg::PWS_NCH-1:0] i_pin_oe,
    // Levels seen by the gate drivers
    output logic [pws_pkg::PWS_NCH-1:0] o_pad
);
    import pws_pkg::*;
    logic [PWS_NCH-1:0] gpio = '0;
    // Released pad wanders, so stale levels never pass
    always_ff @(posedge i_clk_sys) gpio <= ~gpio;
    assign o_pad = (i_pin_oe & i_pin_out) | (~i_pin_oe & gpio);
endmodule
`default_nettype wire

/* File: verif/tb.sv */
/* Testbench of the PWM output stage: registers, events, burst sources.
   Assumes pws_pkg, pws_top, pws_gate_load and pws_chk are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pws_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, perr;
    logic restart, stretch, st;
    logic [4:0] ext;
    logic [5:0] pin, oe, pad, oen, steer, pol, wave;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    pws_evt_t evt;
    int n_mismatch = 0, checks = 0, seed = 32'h7824, n_rst = 0, acc, k;
    pws_top i_pws_top (
        .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_evt(evt), .o_period_restart(restart), .o_period_stretch(stretch),
        .i_burst_input_pin(ext[0]), .i_mod_src({ext[2:1], ext[4:3]}),
        .o_pin_out(pin), .o_pin_oe(oe));
    pws_gate_load i_pws_gate_load (
        .i_clk_sys(clk), .i_pin_out(pin), .i_pin_oe(oe), .o_pad(pad));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (restart === 1'b1) n_rst <= n_rst + 1;
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ev(input pws_evt_t e, input int w);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        @(posedge clk);
        st = stretch;
        repeat (w) @(posedge clk);
    endtask
    task automatic pins;
        chk(32'(oe), 32'(oen));
        chk(32'(pin & oen), 32'((wave ^ pol) & oen));
        chk(32'(pad & oen), 32'((wave ^ pol) & oen));
    endtask
    task automatic src(input int s, input logic v);
        logic [4:0] m;
        m = (s < 5) ? 5'(1 << s) : 5'h00;
        ext <= v ? 5'h1f : ~m;
        apb(1'b1, PWS_OFF_BURST, 32'({3'(s), 2'b00, v, 1'b1}));
        if (v)
            ext <= m;
    endtask
    initial
    begin
        #(25 * 5000);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        rst = 1'b1;
        evt = '0;
        ext = 5'h1f;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge clk);
        chk(32'({pin, oe}), 32'h0);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++)
        begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk(rd, (a == 7) ? 32'h100 : 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], perr}, 32'h1);
        for (int m = 4; m >= 0; m--)
        begin
            apb(1'b1, PWS_OFF_CTRL, 32'(m));
            apb(1'b0, PWS_OFF_CTRL, 32'h0);
            chk(rd, 32'(m));
        end
        apb(1'b1, PWS_OFF_DBAND, 32'h0302);
        for (int i = 0; i < 8; i++)
        begin
            oen = 6'($random(seed));
            steer = 6'($random(seed));
            pol = 6'($random(seed));
            apb(1'b1, PWS_OFF_OEN, 32'(oen));
            apb(1'b1, PWS_OFF_STEER, 32'(steer));
            apb(1'b1, PWS_OFF_POL, 32'(pol));
            wave = steer;
            ev(3'b010, 1);
            pins();
            wave = 6'h00;
            ev(3'b001, 1);
            pins();
        end
        apb(1'b1, PWS_OFF_CTRL, 32'(PWS_MODE_FIXED_COMPL));
        apb(1'b1, PWS_OFF_FRAC, 32'h0b);
        oen = 6'h3f;
        apb(1'b1, PWS_OFF_OEN, 32'(oen));
        acc = 0;
        for (int i = 0; i < 6; i++)
        begin
            ev(3'b011, 1);
            pins();
            acc = acc + 11;
            wave = 6'h00;
            ev(3'b100, 1);
            chk(32'(st), 32'(acc > 15));
            pins();
            acc = acc % 16;
            wave = (i % 2 == 0) ? 6'h01 : 6'h02;
            repeat (6) @(posedge clk);
            pins();
            apb(1'b0, PWS_OFF_STAT, 32'h0);
            chk(32'(rd[15:8]), 32'({4'(acc), 1'b0, wave[1:0], 1'b1}));
        end
        apb(1'b1, PWS_OFF_CTRL, 32'(PWS_MODE_SINGLE));
        steer = 6'h3f;
        apb(1'b1, PWS_OFF_STEER, 32'(steer));
        for (int s = 0; s < 6; s++)
        begin
            src(s, 1'b1);
            wave = steer;
            ev(3'b010, 1);
            pins();
            src(s, 1'b0);
            repeat (6) @(posedge clk);
            pins();
            wave = 6'h00;
            k = n_rst;
            ev(3'b100, 2);
            pins();
            src(s, 1'b1);
            repeat (8) @(posedge clk);
            chk(32'(n_rst - k), 32'h1);
        end
        ext <= 5'h00;
        apb(1'b1, PWS_OFF_BURST, 32'h0);
        wave = steer;
        ev(3'b010, 4);
        pins();
        for (int m = 1; m < 4; m++)
        begin
            apb(1'b1, PWS_OFF_CTRL, 32'(m));
            for (int i = 0; i < 6; i++)
            begin
                steer = 6'(1 << i);
                apb(1'b1, PWS_OFF_STEER, 32'(steer));
                ev((m == 3) ? 3'b100 : 3'b010, 1);
                wave = (m == 1) ? (steer & 6'h15) : steer;
                if (m == 3)
                    wave = 6'(i % 2);
                pins();
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
